// [focc_monitor.sv]
// checker: loop control and config readback properties
`timescale 1ns/1ps
module focc_monitor (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  // loop
  input wire logic carrier_sense,
  input wire logic sync_found,
  input wire logic loops_frozen,
  input wire logic [3:0] loop_gain_x2
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // properties
  // ==========================================
  property p_frz; carrier_sense |=> !loops_frozen; endproperty
  a_frz: assert property (p_frz) else $error("frozen with carrier");
  property p_gain; loop_gain_x2 inside {4'h1, 4'h2, 4'h4, 4'h6, 4'h8}; endproperty
  a_gain: assert property (p_gain) else $error("bad gain");
  property p_pre; !sync_found |=> !loop_gain_x2[0]; endproperty
  a_pre: assert property (p_pre) else $error("half gain before sync");
  property p_ro; pready && !pwrite && paddr == 8'h00 |-> prdata[31:6] == 26'h0; endproperty
  a_ro: assert property (p_ro) else $error("upper bits set");
  property p_rdy; psel && !penable |=> pready ##1 !pready; endproperty
  a_rdy: assert property (p_rdy) else $error("no ready");
  c_frz: cover property (loops_frozen ##1 !loops_frozen);
  c_half: cover property (loop_gain_x2 == 4'h1);
  c_rd: cover property (pready && !pwrite);
endmodule

// [focc_pkg.sv]
// package: register layout, reset values and types for the offset compensation config
package focc_pkg;

  // ==========================================================================
  // register map
  // ==========================================================================
  localparam logic [7:0] CFG_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] OFFSET_ADDR = 8'h08;
  localparam logic [7:0] GAIN_ADDR = 8'h0c;

  // ==========================================================================
  // field positions and resets
  // ==========================================================================
  localparam int FREEZE_BIT = 5;
  localparam int PRE_LSB = 3;
  localparam int POST_BIT = 2;
  localparam int LIMIT_LSB = 0;
  localparam logic FREEZE_RST = 1'b1;
  localparam logic [1:0] PRE_RST = 2'h2;
  localparam logic POST_RST = 1'b1;
  localparam logic [1:0] LIMIT_RST = 2'h2;

  // ==========================================================================
  // types
  // ==========================================================================
  typedef struct packed {
    logic loop_freeze_until_carrier;
    logic [1:0] gain_before_sync;
    logic gain_after_sync;
    logic [1:0] offset_saturation_limit;
  } focc_cfg_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } focc_apb_rsp_t;

endpackage

// [focc_top.sv]
// module: apb config register and loop control for frequency offset compensation
`timescale 1ns/1ps

// Functional notes
// - freeze bit holds compensation and clock recovery loops until carrier sense rises
// - pre-sync gain code 0..3 selects K, 2K, 3K, 4K; resets to code 2
// - post-sync bit 0 keeps pre-sync gain, 1 gives K/2; resets to 1
// - limit code 0 disables compensation (offset forced to 0), 1..3 saturate at bandwidth/8, /4, /2; resets to 2
module focc_top #(
  parameter int OFS_W = 16
) (
  // apb
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // demodulator, same clock
  input wire logic carrier_sense,
  input wire logic sync_found,
  input wire logic signed [OFS_W-1:0] raw_offset,
  input wire logic [OFS_W-1:0] channel_bandwidth,
  // loop control
  output logic loops_frozen,
  output logic [3:0] loop_gain_x2,
  output logic signed [OFS_W-1:0] comp_offset
);

  // ==========================================================================
  // saturation bound
  // ==========================================================================
  function automatic logic [OFS_W-1:0] bound(input logic [1:0] code, input logic [OFS_W-1:0] bw);
    logic [OFS_W-1:0] b;
    b = '0;
    case (code)
      2'h1: b = bw >> 3;
      2'h2: b = bw >> 2;
      2'h3: b = bw >> 1;
      default: b = '0;
    endcase
    return b;
  endfunction

  // ==========================================================================
  // state
  // ==========================================================================
  focc_pkg::focc_cfg_t cfg_q, cfg_d;
  focc_pkg::focc_apb_rsp_t rsp_q, rsp_d;
  logic frz_q, frz_d;
  logic [3:0] gain_q, gain_d;
  logic signed [OFS_W-1:0] ofs_q, ofs_d;

  logic access;
  logic [7:0] cfg_rd;
  logic [OFS_W-1:0] lim;
  logic signed [OFS_W-1:0] lim_s;

  assign access = psel && penable;
  assign lim = bound(cfg_q.offset_saturation_limit, channel_bandwidth);
  // bound is at most bw/2, so its top bit is clear and it fits the signed range
  assign lim_s = signed'(lim);

  always_comb begin
    cfg_rd = {2'h0, cfg_q};
  end

  // ==========================================================================
  // register write and apb response
  // ==========================================================================
  always_comb begin
    cfg_d = cfg_q;
    rsp_d = rsp_q;
    rsp_d.pready = 1'b0;
    rsp_d.pslverr = 1'b0;
    rsp_d.prdata = 32'h0;
    if (psel && !penable) begin
      rsp_d.pready = 1'b1;
      if (paddr == focc_pkg::CFG_ADDR) begin
        rsp_d.prdata = {24'h0, cfg_rd};
      end else if (paddr == focc_pkg::STATUS_ADDR) begin
        rsp_d.prdata = {30'h0, sync_found, frz_q};
        rsp_d.pslverr = pwrite;
      end else if (paddr == focc_pkg::OFFSET_ADDR) begin
        rsp_d.prdata = 32'(ofs_q);
        rsp_d.pslverr = pwrite;
      end else if (paddr == focc_pkg::GAIN_ADDR) begin
        rsp_d.prdata = {28'h0, gain_q};
        rsp_d.pslverr = pwrite;
      end else begin
        rsp_d.pslverr = 1'b1;
      end
    end
    // write lands only at the edge where pready is sampled high
    if (access && rsp_q.pready) begin
      rsp_d = '0;
      if (pwrite && paddr == focc_pkg::CFG_ADDR) begin
        cfg_d = pwdata[5:0];
      end
    end
  end

  // ==========================================================================
  // loop control
  // ==========================================================================
  always_comb begin
    frz_d = cfg_q.loop_freeze_until_carrier && !carrier_sense;
    if (sync_found && cfg_q.gain_after_sync) begin
      gain_d = 4'h1;
    end else begin
      gain_d = ({2'h0, cfg_q.gain_before_sync} + 4'h1) << 1;
    end
    if (cfg_q.offset_saturation_limit == 2'h0) begin
      ofs_d = '0;
    end else if (frz_d) begin
      ofs_d = ofs_q;
    end else if (raw_offset > lim_s) begin
      ofs_d = lim_s;
    end else if (raw_offset < -lim_s) begin
      ofs_d = -lim_s;
    end else begin
      ofs_d = raw_offset;
    end
  end

  // ==========================================================================
  // registers
  // ==========================================================================
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_q <= {focc_pkg::FREEZE_RST, focc_pkg::PRE_RST, focc_pkg::POST_RST, focc_pkg::LIMIT_RST};
      rsp_q <= '0;
      frz_q <= 1'b1;
      gain_q <= 4'h6;
      ofs_q <= '0;
    end else begin
      cfg_q <= cfg_d;
      rsp_q <= rsp_d;
      frz_q <= frz_d;
      gain_q <= gain_d;
      ofs_q <= ofs_d;
    end
  end

  assign prdata = rsp_q.prdata;
  assign pready = rsp_q.pready;
  assign pslverr = rsp_q.pslverr;
  assign loops_frozen = frz_q;
  assign loop_gain_x2 = gain_q;
  assign comp_offset = ofs_q;

endmodule

// [focc_top_bench.sv]
// testbench: apb sequences against the config block
`timescale 1ns/1ps
module focc_top_bench;
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err;
  logic carrier_sense = 0, sync_found = 0, loops_frozen;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic signed [15:0] raw_offset = 16'sh0005, comp_offset;
  logic [15:0] channel_bandwidth = 16'h03e8;
  logic [3:0] loop_gain_x2;
  int miscompares = 0, comparisons = 0;
  always #4 pclk = ~pclk;
  focc_top focc_top_inst (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .carrier_sense(carrier_sense),
    .sync_found(sync_found),
    .raw_offset(raw_offset),
    .channel_bandwidth(channel_bandwidth),
    .loops_frozen(loops_frozen),
    .loop_gain_x2(loop_gain_x2),
    .comp_offset(comp_offset)
  );
  task automatic test_done;
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("MISMATCH %s exp %h got %h", n, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin
      miscompares++;
      test_done();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  initial begin
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, 8'h00, 0);
    chk("cfg", 32'h36, rd);
    chk("gain", 6, loop_gain_x2);
    $display("reset test done");
    for (int i = 0; i < 4; i++) begin
      apb(1, 8'h00, 32'h04 | (i << 3));
      repeat (2) @(posedge pclk);
      chk("pre gain", 2 * i + 2, loop_gain_x2);
    end
    sync_found <= 1'b1;
    for (int j = 0; j < 2; j++) begin
      apb(1, 8'h00, 32'h08 | (j << 2));
      repeat (2) @(posedge pclk);
      chk("post gain", j ? 1 : 4, loop_gain_x2);
    end
    $display("gain test done");
    apb(1, 8'h00, 32'hff);
    apb(0, 8'h00, 0);
    chk("cfg ro", 32'h3f, rd);
    chk("frozen", 1, loops_frozen);
    carrier_sense <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("thawed", 0, loops_frozen);
    chk("offset", 5, comp_offset);
    apb(0, 8'h04, 0);
    chk("status", 2, rd);
    apb(1, 8'h00, 32'h01);
    raw_offset <= 16'sd300;
    repeat (3) @(posedge pclk);
    chk("sat hi", 125, comp_offset);
    raw_offset <= -16'sd300;
    repeat (3) @(posedge pclk);
    chk("sat lo", -125, comp_offset);
    carrier_sense <= 1'b0;
    apb(1, 8'h00, 32'h21);
    raw_offset <= 16'sd0;
    repeat (3) @(posedge pclk);
    chk("held", -125, comp_offset);
    carrier_sense <= 1'b1;
    repeat (3) @(posedge pclk);
    chk("released", 0, comp_offset);
    raw_offset <= 16'sd5;
    apb(1, 8'h00, 32'h00);
    repeat (3) @(posedge pclk);
    chk("no comp", 0, comp_offset);
    apb(0, 8'h08, 0);
    chk("offset reg", 0, rd[15:0]);
    $display("loop test done");
    apb(1, 8'h04, 1);
    chk("ro err", 1, err);
    apb(0, 8'h10, 0);
    chk("unmapped", 0, rd);
    chk("unmapped err", 1, err);
    $display("bus test done");
    test_done();
  end
endmodule
bind focc_top focc_monitor focc_monitor_inst (.*);
